// File: testbench/secl_eeprom_model.sv
// Behavioural serial memory, mode 0, with selectable address byte count
`timescale 1ns/1ns
`default_nettype none

module secl_eeprom_model (
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic [1:0] abytes_i,
	output logic            miso_o
);
	logic [7:0]  mem [0:255];
	logic [7:0]  op;
	logic [7:0]  isr;
	logic [7:0]  osr;
	logic [23:0] adr;
	logic        wel = 1'b0;
	int          nbit;
	int          nbyte;
	// ==========================================================================
	// Frame control, line pulled down when idle
	always @(cs_n_i) begin
		nbit = 0;
		nbyte = 0;
		osr = 8'h00;
		miso_o = 1'b0;
		if (cs_n_i && op == 8'h02) wel = 1'b0;
	end
	always @(posedge sck_i) if (!cs_n_i) begin
		isr = {isr[6:0], mosi_i};
		nbit++;
		if (nbit == 8) begin
			nbit = 0;
			nbyte++;
			if (nbyte == 1) begin
				op = isr;
				adr = 24'h00_0000;
				if (op == 8'h06) wel = 1'b1;
				if (op == 8'h05) osr = {6'h00, wel, 1'b0};
			end else if (nbyte <= abytes_i + 1) adr = {adr[15:0], isr};
			else if (op == 8'h02 && wel) begin
				mem[adr[7:0]] = isr;
				adr++;
			end
			if (op == 8'h03 && nbyte > abytes_i) begin
				osr = mem[adr[7:0]];
				adr++;
			end
		end
	end
	always @(negedge sck_i) if (!cs_n_i) begin
		miso_o = osr[7];
		osr = {osr[6:0], 1'b0};
	end
endmodule

`default_nettype wire

// File: testbench/secl_loader_assertions.sv
// Port-level assertions for the configuration loader
`timescale 1ns/1ns
`default_nettype none

module secl_loader_assertions (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        fundamental_reset_n_i,
	input wire logic        reg_rd_en_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        eeprom_cs_n_o,
	input wire logic        eeprom_serial_clock_o,
	input wire logic        eeprom_serial_out_o,
	input wire logic        cfg_wr_o,
	input wire logic [2:0]  cfg_block_o,
	input wire logic        prog_wr_o,
	input wire logic [14:0] prog_addr_o,
	input wire logic        mcu_reset_o,
	input wire logic        usb_enable_o,
	input wire logic        pcie_enable_o,
	input wire logic        load_done_o,
	input wire logic        irq_o
);
	// ==========================================================================
	// Checks
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sck_in_frame_a: assert property (eeprom_serial_clock_o |-> !eeprom_cs_n_o)
		else $error("serial clock toggles without select");
	data_hold_a: assert property (eeprom_serial_clock_o && $past(eeprom_serial_clock_o) |->
		$stable(eeprom_serial_out_o)) else $error("serial out moves while clock high");
	auto_start_a: assert property ($rose(fundamental_reset_n_i) |-> ##[1:8] !eeprom_cs_n_o)
		else $error("load does not start");
	restart_a: assert property ((!fundamental_reset_n_i) [*5] |->
		eeprom_cs_n_o && mcu_reset_o && !load_done_o) else $error("fundamental reset ignored");
	entry_block_a: assert property (cfg_wr_o |-> cfg_block_o inside {3'h0, 3'h2, 3'h3, 3'h4})
		else $error("reserved block written");
	entry_order_a: assert property (cfg_wr_o |-> !load_done_o && !prog_wr_o)
		else $error("entry write outside load");
	prog_step_a: assert property (prog_wr_o |=> prog_addr_o == $past(prog_addr_o) + 15'h0001)
		else $error("program address not stepping");
	mcu_hold_a: assert property (prog_wr_o |-> mcu_reset_o)
		else $error("controller released during copy");
	side_enable_a: assert property (!(usb_enable_o && pcie_enable_o) &&
		((usb_enable_o || pcie_enable_o) == load_done_o)) else $error("side enable wrong");
	irq_pulse_a: assert property (irq_o |-> load_done_o && !$past(irq_o))
		else $error("interrupt pulse wrong");
	unmapped_zero_a: assert property (reg_rd_en_i && reg_addr_i == 12'h3FC |=>
		reg_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
endmodule

bind secl_loader secl_loader_assertions i_chk (
	.ref_clk_i, .rst_n_i, .fundamental_reset_n_i, .reg_rd_en_i, .reg_addr_i, .reg_rdata_o,
	.eeprom_cs_n_o, .eeprom_serial_clock_o, .eeprom_serial_out_o, .cfg_wr_o, .cfg_block_o,
	.prog_wr_o, .prog_addr_o, .mcu_reset_o, .usb_enable_o, .pcie_enable_o, .load_done_o, .irq_o
);

`default_nettype wire

// File: testbench/test_spi_eeprom_config_loader.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ns
`default_nettype none

module test_spi_eeprom_config_loader;
	logic        ref_clk_i, rst_n_i, fundamental_reset_n_i, root_complex_strap_i;
	logic        reg_wr_en_i, reg_rd_en_i, eeprom_serial_in_i, eeprom_cs_n_o;
	logic        eeprom_serial_clock_o, eeprom_serial_out_o, cfg_wr_o, prog_wr_o;
	logic        mcu_reset_o, usb_enable_o, pcie_enable_o, load_done_o, irq_o;
	logic [11:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, cfg_data_o, rd;
	logic [2:0]  cfg_block_o;
	logic [9:0]  cfg_dword_o;
	logic [14:0] prog_addr_o;
	logic [7:0]  prog_data_o, d, img [0:255];
	logic [1:0]  abytes;
	logic [31:0] seed = 32'h0000_0006;
	logic [44:0] exp_q [$];
	int          num_errors, comparisons, irqs;

	secl_loader i_dut (.ref_clk_i, .rst_n_i, .fundamental_reset_n_i, .root_complex_strap_i,
		.reg_wr_en_i, .reg_rd_en_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .eeprom_cs_n_o,
		.eeprom_serial_clock_o, .eeprom_serial_out_o, .eeprom_serial_in_i, .cfg_wr_o,
		.cfg_block_o, .cfg_dword_o, .cfg_data_o, .prog_wr_o, .prog_addr_o, .prog_data_o,
		.mcu_reset_o, .usb_enable_o, .pcie_enable_o, .load_done_o, .irq_o);
	secl_eeprom_model i_mem (.cs_n_i(eeprom_cs_n_o), .sck_i(eeprom_serial_clock_o),
		.mosi_i(eeprom_serial_out_o), .abytes_i(abytes), .miso_o(eeprom_serial_in_i));

	always #4 ref_clk_i = ~ref_clk_i;
	// ==========================================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic print_verdict();
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string name, input logic [44:0] want, input logic [44:0] seen);
		comparisons++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic check_q(input logic [44:0] seen);
		logic [44:0] e;
		e = 'x;
		if (exp_q.size() > 0) e = exp_q.pop_front();
		check("load write", e, seen);
	endtask
	always @(negedge ref_clk_i) begin
		if (cfg_wr_o === 1'b1) check_q({cfg_block_o, cfg_dword_o, cfg_data_o});
		if (prog_wr_o === 1'b1) check_q({22'h3F_FFFF, prog_addr_o, prog_data_o});
		if (irq_o === 1'b1) irqs++;
	end
	task automatic reg_op(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		@(posedge ref_clk_i);
		reg_wr_en_i <= wr;
		reg_rd_en_i <= !wr;
		reg_addr_i <= addr;
		reg_wdata_i <= data;
		@(posedge ref_clk_i);
		reg_wr_en_i <= 1'b0;
		reg_rd_en_i <= 1'b0;
		#1 rd = reg_rdata_o;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 500; i++) begin
			reg_op(1'b0, 12'h260, 32'h0000_0000);
			if (rd[19] === 1'b0) return;
		end
		num_errors++;
		print_verdict();
	endtask
	task automatic sw_byte(input logic rd_not_wr, input logic [7:0] val);
		wait_idle();
		reg_op(1'b1, 12'h260, (rd_not_wr ? 32'h0005_0000 : 32'h0006_0000) | val);
		wait_idle();
		check("select", 1'b0, eeprom_cs_n_o);
	endtask
	task automatic ee_off();
		wait_idle();
		reg_op(1'b1, 12'h260, 32'h0000_0000);
		@(posedge ref_clk_i);
		#1;
		check("select", 1'b1, eeprom_cs_n_o);
	endtask
	// ==========================================================================
	// One load with its expected writes
	task automatic load(input logic [7:0] sig, input logic strap, input logic [7:0] f);
		int n;
		int p;
		logic [15:0] a;
		logic v;
		for (int k = 0; k < 256; k++) img[k] = (sig == 8'h00) ? 8'h00 : 8'(rnd());
		if (sig != 8'h00) begin
			img[0] = sig;
			img[1] = f;
			{img[3], img[2]} = 16'h0012;
			{img[9], img[8], img[7], img[6], img[5], img[4]} = 48'h0000_0004_009A;
			img[11][4:2] = 3'h5;
			img[17][4:2] = 3'h4;
			if (f == 8'h04)
				{img[21], img[20], img[19], img[18], img[17], img[16]} = 48'h0002_0006_0098;
			{img[23], img[22]} = 16'h0003;
		end
		for (int k = 0; k < 256; k++) i_mem.mem[k] = img[k];
		v = (sig == 8'h5A);
		p = f[0] ? 2 : 4 + {img[3], img[2]};
		if (v && !f[0]) for (int e = 4; e + 6 <= p; e += 6) begin
			a = {img[e + 1], img[e]};
			if (a[12:10] inside {3'h0, 3'h2, 3'h3, 3'h4})
				exp_q.push_back({a[12:0], img[e + 5], img[e + 4], img[e + 3], img[e + 2]});
		end
		if (v && f[1]) for (int i = 0; i < {img[p + 1], img[p]}; i++)
			exp_q.push_back({22'h3F_FFFF, 15'(i), img[p + 2 + i]});
		@(posedge ref_clk_i);
		root_complex_strap_i <= strap;
		fundamental_reset_n_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		fundamental_reset_n_i <= 1'b1;
		for (n = 0; n < 40000 && load_done_o !== 1'b1; n++) @(posedge ref_clk_i);
		if (n == 40000) num_errors++;
		if (n == 40000) print_verdict();
		reg_op(1'b0, 12'h260, 32'h0000_0000);
		check("width", v ? abytes : 2'b00, rd[23:22]);
		check("signature", v, rd[20]);
		check("control entry", (f == 8'h04) ? 8'h06 : 8'h00, rd[7:0]);
		check("mcu reset", !(v && f[1] && f[2]), mcu_reset_o);
		check("enables", {strap, !strap}, {usb_enable_o, pcie_enable_o});
		check("missing writes", 45'h0, exp_q.size());
		reg_op(1'b0, 12'h268, 32'h0000_0000);
		check("clock select", (v && !f[0]) ? 3'h4 : 3'h0, rd[2:0]);
	endtask
	// ==========================================================================
	// Main sequence
	initial begin
		{ref_clk_i, rst_n_i, fundamental_reset_n_i, root_complex_strap_i} = 4'h0;
		{reg_wr_en_i, reg_rd_en_i, reg_addr_i, reg_wdata_i} = 46'h0;
		abytes = 2'h2;
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		load(8'h00, 1'b1, 8'h06);
		load(8'(rnd()) | 8'h01, 1'b0, 8'h06);
		for (int w = 1; w < 4; w++) begin
			abytes <= 2'(w);
			load(8'h5A, 1'(rnd()), w == 1 ? 8'h06 : (w == 2 ? 8'h03 : 8'h04));
		end
		d = 8'(rnd());
		sw_byte(1'b0, 8'h06);
		ee_off();
		sw_byte(1'b0, 8'h05);
		sw_byte(1'b1, 8'h00);
		check("status", 8'h02, rd[15:8]);
		ee_off();
		sw_byte(1'b0, 8'h02);
		repeat (2) sw_byte(1'b0, 8'h00);
		sw_byte(1'b0, 8'h40);
		sw_byte(1'b0, d);
		ee_off();
		sw_byte(1'b0, 8'h03);
		repeat (2) sw_byte(1'b0, 8'h00);
		sw_byte(1'b0, 8'h40);
		sw_byte(1'b1, 8'h00);
		check("read byte", d, rd[15:8]);
		ee_off();
		reg_op(1'b0, 12'h3FC, 32'h0000_0000);
		check("unmapped", 32'h0000_0000, rd);
		check("interrupts", 45'h13, irqs);
		print_verdict();
	end
endmodule

`default_nettype wire

// File: verilog/secl_loader.sv
// Serial memory configuration loader with software byte access
`timescale 1ns/1ns
`default_nettype none
`include "secl_regs.svh"

module secl_loader (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        fundamental_reset_n_i,
	input  wire logic        root_complex_strap_i,
	input  wire logic        reg_wr_en_i,
	input  wire logic        reg_rd_en_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	output logic      [31:0] reg_rdata_o,
	output logic             eeprom_cs_n_o,
	output logic             eeprom_serial_clock_o,
	output logic             eeprom_serial_out_o,
	input  wire logic        eeprom_serial_in_i,
	output logic             cfg_wr_o,
	output logic      [2:0]  cfg_block_o,
	output logic      [9:0]  cfg_dword_o,
	output logic      [31:0] cfg_data_o,
	output logic             prog_wr_o,
	output logic      [14:0] prog_addr_o,
	output logic      [7:0]  prog_data_o,
	output logic             mcu_reset_o,
	output logic             usb_enable_o,
	output logic             pcie_enable_o,
	output logic             load_done_o,
	output logic             irq_o
);

	secl_pkg::secl_load_t r_reg, r_next;
	logic       sh_done;
	logic [7:0] sh_rx;

	// ==========================================================================
	// Decoding helpers
	function automatic logic [7:0] period_of(input logic [2:0] code);
		case (code)
			3'h1:    period_of = `SECL_PER_2M5HZ;
			3'h2:    period_of = `SECL_PER_5MHZ;
			3'h3:    period_of = `SECL_PER_9M62HZ;
			3'h4:    period_of = `SECL_PER_17M86HZ;
			default: period_of = `SECL_PER_1MHZ;
		endcase
	endfunction

	function automatic logic block_ok(input logic [2:0] blk);
		block_ok = (blk == `SECL_BLK_PORT0) || (blk == `SECL_BLK_PORT2) ||
			(blk == `SECL_BLK_CTRL_TYPE0) || (blk == `SECL_BLK_CTRL_REGS);
	endfunction

	function automatic logic [31:0] ctrl_view(input secl_pkg::secl_load_t s);
		ctrl_view = 32'h0000_0000;
		ctrl_view[`SECL_F_WDATA_LO +: 8] = s.wdata;
		ctrl_view[`SECL_F_RDATA_LO +: 8] = s.rdata;
		ctrl_view[`SECL_F_RD_START]      = s.rd_go;
		ctrl_view[`SECL_F_WR_START]      = s.wr_go;
		ctrl_view[`SECL_F_CS_EN]         = s.cs_en;
		ctrl_view[`SECL_F_BUSY]          = s.busy_q;
		ctrl_view[`SECL_F_SIG_OK]        = s.sig_ok;
		ctrl_view[`SECL_F_LOAD_DONE]     = s.load_done;
		ctrl_view[`SECL_F_WIDTH_LO +: 2] = s.width;
	endfunction

	// ==========================================================================
	// Byte shifter
	secl_shifter u_shifter (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.period_i  (period_of(r_reg.freq)),
		.start_i   (r_reg.sh_start),
		.tx_i      (r_reg.sh_tx),
		.miso_i    (r_reg.miso_s2),
		.sck_o     (eeprom_serial_clock_o),
		.mosi_o    (eeprom_serial_out_o),
		.done_o    (sh_done),
		.rx_o      (sh_rx)
	);

	// ==========================================================================
	// Load sequencer and register file
	always_comb begin
		r_next = r_reg;
		r_next.fr_s1    = fundamental_reset_n_i;
		r_next.fr_s2    = r_reg.fr_s1;
		r_next.strap_s1 = root_complex_strap_i;
		r_next.strap_s2 = r_reg.strap_s1;
		r_next.miso_s1  = eeprom_serial_in_i;
		r_next.miso_s2  = r_reg.miso_s1;
		r_next.sh_start = 1'b0;
		r_next.sh_tx    = 8'h00;
		r_next.cfg_wr   = 1'b0;
		r_next.prog_wr  = 1'b0;

		case (r_reg.st)
			secl_pkg::ST_RESET: begin
				if (r_reg.fr_s2) begin
					r_next.cs_n     = 1'b0;
					r_next.sh_start = 1'b1;
					r_next.sh_tx    = `SECL_READ_OPCODE;
					r_next.st       = secl_pkg::ST_CMD;
				end
			end
			secl_pkg::ST_CMD: begin
				if (sh_done) begin
					r_next.probe    = 3'h1;
					r_next.sh_start = 1'b1;
					r_next.st       = secl_pkg::ST_PROBE;
				end
			end
			secl_pkg::ST_PROBE: begin
				if (sh_done) begin
					if (sh_rx == `SECL_SIGNATURE && r_reg.probe != 3'h1) begin
						r_next.width    = r_reg.probe[1:0] - 2'h1;
						r_next.sig_ok   = 1'b1;
						r_next.sh_start = 1'b1;
						r_next.st       = secl_pkg::ST_FMT;
					end else if (sh_rx != 8'h00 || r_reg.probe == `SECL_PROBE_LIMIT) begin
						r_next.width = 2'h0;
						r_next.st    = secl_pkg::ST_FINISH;
					end else begin
						r_next.probe    = r_reg.probe + 3'h1;
						r_next.sh_start = 1'b1;
					end
				end
			end
			secl_pkg::ST_FMT: begin
				if (sh_done) begin
					r_next.fmt      = sh_rx;
					r_next.cnt      = 16'h0000;
					r_next.sh_start = 1'b1;
					if (!sh_rx[`SECL_FMT_NO_CFG])
						r_next.st = secl_pkg::ST_CNTL;
					else if (sh_rx[`SECL_FMT_MEM_LOAD])
						r_next.st = secl_pkg::ST_PCNTL;
					else begin
						r_next.sh_start = 1'b0;
						r_next.st       = secl_pkg::ST_FINISH;
					end
				end
			end
			secl_pkg::ST_CNTL: begin
				if (sh_done) begin
					r_next.cnt[7:0] = sh_rx;
					r_next.sh_start = 1'b1;
					r_next.st       = secl_pkg::ST_CNTH;
				end
			end
			secl_pkg::ST_CNTH: begin
				if (sh_done) begin
					r_next.cnt[15:8] = sh_rx;
					r_next.idx       = 3'h0;
					r_next.sh_start  = 1'b1;
					if ({sh_rx, r_reg.cnt[7:0]} != 16'h0000)
						r_next.st = secl_pkg::ST_ENTRY;
					else if (r_reg.fmt[`SECL_FMT_MEM_LOAD])
						r_next.st = secl_pkg::ST_PCNTL;
					else begin
						r_next.sh_start = 1'b0;
						r_next.st       = secl_pkg::ST_FINISH;
					end
				end
			end
			secl_pkg::ST_ENTRY: begin
				if (sh_done) begin
					r_next.ent = {sh_rx, r_reg.ent[39:8]};
					r_next.idx = r_reg.idx + 3'h1;
					r_next.cnt = r_reg.cnt - 16'h0001;
					if (r_reg.idx == `SECL_ENTRY_LAST) begin
						r_next.idx = 3'h0;
						if (block_ok(r_reg.ent[12:10])) begin
							r_next.cfg_wr   = 1'b1;
							r_next.cfg_blk  = r_reg.ent[12:10];
							r_next.cfg_dw   = r_reg.ent[9:0];
							r_next.cfg_data = {sh_rx, r_reg.ent[39:16]};
						end
						if (r_reg.ent[12:10] == `SECL_BLK_PORT0 &&
							r_reg.ent[9:0] == `SECL_DW_CLOCK_FREQ)
							r_next.freq = r_reg.ent[18:16];
						if (r_reg.ent[12:10] == `SECL_BLK_PORT0 &&
							r_reg.ent[9:0] == `SECL_DW_STATUS_CTRL) begin
							r_next.wdata = r_reg.ent[23:16];
							r_next.rd_go = r_reg.ent[16 + `SECL_F_RD_START];
							r_next.wr_go = r_reg.ent[16 + `SECL_F_WR_START];
							r_next.cs_en = r_reg.ent[16 + `SECL_F_CS_EN];
						end
					end
					r_next.sh_start = 1'b1;
					if (r_reg.cnt == 16'h0001) begin
						if (r_reg.fmt[`SECL_FMT_MEM_LOAD])
							r_next.st = secl_pkg::ST_PCNTL;
						else begin
							r_next.sh_start = 1'b0;
							r_next.st       = secl_pkg::ST_FINISH;
						end
					end
				end
			end
			secl_pkg::ST_PCNTL: begin
				if (sh_done) begin
					r_next.cnt[7:0] = sh_rx;
					r_next.sh_start = 1'b1;
					r_next.st       = secl_pkg::ST_PCNTH;
				end
			end
			secl_pkg::ST_PCNTH: begin
				if (sh_done) begin
					r_next.cnt[15:8] = sh_rx;
					r_next.prog_addr = 15'h0000;
					if ({sh_rx, r_reg.cnt[7:0]} != 16'h0000) begin
						r_next.sh_start = 1'b1;
						r_next.st       = secl_pkg::ST_PROG;
					end else
						r_next.st = secl_pkg::ST_FINISH;
				end
			end
			secl_pkg::ST_PROG: begin
				if (sh_done) begin
					r_next.prog_wr   = 1'b1;
					r_next.prog_addr = r_reg.prog_addr;
					r_next.prog_data = sh_rx;
					r_next.cnt       = r_reg.cnt - 16'h0001;
					if (r_reg.cnt == 16'h0001)
						r_next.st = secl_pkg::ST_FINISH;
					else
						r_next.sh_start = 1'b1;
				end
			end
			secl_pkg::ST_FINISH: begin
				r_next.cs_n      = 1'b1;
				r_next.load_done = 1'b1;
				r_next.usb_en    = r_reg.strap_s2;
				r_next.pcie_en   = !r_reg.strap_s2;
				r_next.mcu_rst   = !(r_reg.sig_ok && r_reg.fmt[`SECL_FMT_MEM_LOAD] &&
					r_reg.fmt[`SECL_FMT_START_EN]);
				r_next.st        = secl_pkg::ST_IDLE;
			end
			secl_pkg::ST_IDLE: begin
				r_next.cs_n = !r_reg.cs_en;
				if (r_reg.rd_go || r_reg.wr_go) begin
					r_next.cs_n     = 1'b0;
					r_next.sh_start = 1'b1;
					r_next.sh_tx    = r_reg.rd_go ? 8'h00 : r_reg.wdata;
					r_next.st       = secl_pkg::ST_SWOP;
				end
			end
			secl_pkg::ST_SWOP: begin
				if (sh_done) begin
					if (r_reg.rd_go)
						r_next.rdata = sh_rx;
					r_next.rd_go = 1'b0;
					r_next.wr_go = 1'b0;
					r_next.st    = secl_pkg::ST_IDLE;
				end
			end
			default: r_next.st = secl_pkg::ST_RESET;
		endcase
		if (r_reg.prog_wr)
			r_next.prog_addr = r_reg.prog_addr + 15'h0001;

		// Register port
		if (reg_wr_en_i && reg_addr_i == `SECL_OFS_STATUS_CTRL) begin
			r_next.wdata = reg_wdata_i[`SECL_F_WDATA_LO +: 8];
			r_next.cs_en = reg_wdata_i[`SECL_F_CS_EN];
			if (reg_wdata_i[`SECL_F_RD_START])
				r_next.rd_go = 1'b1;
			if (reg_wdata_i[`SECL_F_WR_START])
				r_next.wr_go = 1'b1;
		end
		if (reg_wr_en_i && reg_addr_i == `SECL_OFS_CLOCK_FREQ)
			r_next.freq = reg_wdata_i[2:0];
		r_next.bus_rdata = 32'h0000_0000;
		if (reg_rd_en_i && reg_addr_i == `SECL_OFS_STATUS_CTRL)
			r_next.bus_rdata = ctrl_view(r_reg);
		if (reg_rd_en_i && reg_addr_i == `SECL_OFS_CLOCK_FREQ)
			r_next.bus_rdata = {29'h0000_0000, r_reg.freq};

		// Busy status and its falling-edge interrupt
		r_next.busy_q = (r_next.st != secl_pkg::ST_IDLE);
		r_next.irq    = r_reg.busy_q && !r_next.busy_q;

		// Fundamental reset holds the sequencer and controller
		if (!r_reg.fr_s2) begin
			r_next.st        = secl_pkg::ST_RESET;
			r_next.cs_n      = 1'b1;
			r_next.mcu_rst   = 1'b1;
			r_next.load_done = 1'b0;
			r_next.sig_ok    = 1'b0;
			r_next.width     = 2'h0;
			r_next.usb_en    = 1'b0;
			r_next.pcie_en   = 1'b0;
			r_next.freq      = `SECL_FREQ_RESET;
			r_next.rd_go     = 1'b0;
			r_next.wr_go     = 1'b0;
			r_next.cs_en     = 1'b0;
			r_next.wdata     = 8'h00;
			r_next.rdata     = 8'h00;
			r_next.busy_q    = 1'b1;
			r_next.irq       = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_reg         <= '0;
			r_reg.st      <= secl_pkg::ST_RESET;
			r_reg.cs_n    <= 1'b1;
			r_reg.mcu_rst <= 1'b1;
			r_reg.busy_q  <= 1'b1;
			r_reg.freq    <= `SECL_FREQ_RESET;
		end else
			r_reg <= r_next;
	end

	// ==========================================================================
	// Outputs
	assign reg_rdata_o   = r_reg.bus_rdata;
	assign eeprom_cs_n_o = r_reg.cs_n;
	assign cfg_wr_o      = r_reg.cfg_wr;
	assign cfg_block_o   = r_reg.cfg_blk;
	assign cfg_dword_o   = r_reg.cfg_dw;
	assign cfg_data_o    = r_reg.cfg_data;
	assign prog_wr_o     = r_reg.prog_wr;
	assign prog_addr_o   = r_reg.prog_addr;
	assign prog_data_o   = r_reg.prog_data;
	assign mcu_reset_o   = r_reg.mcu_rst;
	assign usb_enable_o  = r_reg.usb_en;
	assign pcie_enable_o = r_reg.pcie_en;
	assign load_done_o   = r_reg.load_done;
	assign irq_o         = r_reg.irq;

endmodule
`default_nettype wire

// File: verilog/secl_pkg.sv
// Types shared by the loader and its serial byte shifter
package secl_pkg;

	typedef enum logic [3:0] {
		ST_RESET, ST_CMD, ST_PROBE, ST_FMT, ST_CNTL, ST_CNTH, ST_ENTRY,
		ST_PCNTL, ST_PCNTH, ST_PROG, ST_FINISH, ST_IDLE, ST_SWOP
	} secl_state_t;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic        sck;
		logic        mosi;
		logic [7:0]  per;
		logic [7:0]  cnt;
		logic [2:0]  bitn;
		logic [7:0]  sh;
		logic [7:0]  rx;
	} secl_shift_t;

	typedef struct packed {
		secl_state_t st;
		logic        fr_s1;
		logic        fr_s2;
		logic        strap_s1;
		logic        strap_s2;
		logic        miso_s1;
		logic        miso_s2;
		logic        cs_n;
		logic [7:0]  fmt;
		logic [15:0] cnt;
		logic [2:0]  idx;
		logic [39:0] ent;
		logic [2:0]  probe;
		logic [1:0]  width;
		logic        sig_ok;
		logic        load_done;
		logic        mcu_rst;
		logic        usb_en;
		logic        pcie_en;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        rd_go;
		logic        wr_go;
		logic        cs_en;
		logic [2:0]  freq;
		logic        busy_q;
		logic        irq;
		logic        cfg_wr;
		logic [2:0]  cfg_blk;
		logic [9:0]  cfg_dw;
		logic [31:0] cfg_data;
		logic        prog_wr;
		logic [14:0] prog_addr;
		logic [7:0]  prog_data;
		logic [31:0] bus_rdata;
		logic        sh_start;
		logic [7:0]  sh_tx;
	} secl_load_t;

endpackage

// File: verilog/secl_regs.svh
// Register offsets, field positions, timing counts and opcodes of the loader
`ifndef SECL_REGS_SVH
`define SECL_REGS_SVH

// ==========================================================================
// Register map
`define SECL_OFS_STATUS_CTRL  12'h260
`define SECL_OFS_CLOCK_FREQ   12'h268
`define SECL_DW_STATUS_CTRL   10'h098
`define SECL_DW_CLOCK_FREQ    10'h09A
`define SECL_BLK_PORT0        3'h0
`define SECL_BLK_PORT2        3'h2
`define SECL_BLK_CTRL_TYPE0   3'h3
`define SECL_BLK_CTRL_REGS    3'h4

// ==========================================================================
// Control register fields
`define SECL_F_WDATA_LO       0
`define SECL_F_RDATA_LO       8
`define SECL_F_RD_START       16
`define SECL_F_WR_START       17
`define SECL_F_CS_EN          18
`define SECL_F_BUSY           19
`define SECL_F_SIG_OK         20
`define SECL_F_LOAD_DONE      21
`define SECL_F_WIDTH_LO       22
`define SECL_FREQ_RESET       3'h0

// ==========================================================================
// Memory layout and opcodes
`define SECL_SIGNATURE        8'h5A
`define SECL_READ_OPCODE      8'h03
`define SECL_PROBE_LIMIT      3'h4
`define SECL_FMT_NO_CFG       0
`define SECL_FMT_MEM_LOAD     1
`define SECL_FMT_START_EN     2
`define SECL_ENTRY_LAST       3'h5

// ==========================================================================
// Serial clock periods in reference clock cycles (125 MHz)
`define SECL_PER_1MHZ         8'h7D
`define SECL_PER_2M5HZ        8'h32
`define SECL_PER_5MHZ         8'h19
`define SECL_PER_9M62HZ       8'h0D
`define SECL_PER_17M86HZ      8'h07

`endif

// File: verilog/secl_shifter.sv
// Serial byte shifter with divided serial clock, mode 0, MSB first
`timescale 1ns/1ns
`default_nettype none
`include "secl_regs.svh"

module secl_shifter (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] period_i,
	input  wire logic       start_i,
	input  wire logic [7:0] tx_i,
	input  wire logic       miso_i,
	output logic            sck_o,
	output logic            mosi_o,
	output logic            done_o,
	output logic [7:0]      rx_o
);

	secl_pkg::secl_shift_t r_reg, r_next;

	// ==========================================================================
	// Bit timing
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (!r_reg.busy) begin
			if (start_i) begin
				r_next.busy = 1'b1;
				r_next.per  = period_i;
				r_next.sh   = tx_i;
				r_next.mosi = tx_i[7];
				r_next.cnt  = 8'h00;
				r_next.bitn = 3'h0;
			end
		end else begin
			r_next.cnt = r_reg.cnt + 8'h01;
			if (r_reg.cnt == (r_reg.per >> 1))
				r_next.sck = 1'b1;
			if (r_reg.cnt == r_reg.per - 8'h01) begin
				r_next.sck  = 1'b0;
				r_next.cnt  = 8'h00;
				r_next.sh   = {r_reg.sh[6:0], miso_i};
				r_next.mosi = r_reg.sh[6];
				r_next.bitn = r_reg.bitn + 3'h1;
				if (r_reg.bitn == 3'h7) begin
					r_next.busy = 1'b0;
					r_next.done = 1'b1;
					r_next.rx   = {r_reg.sh[6:0], miso_i};
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign sck_o  = r_reg.sck;
	assign mosi_o = r_reg.mosi;
	assign done_o = r_reg.done;
	assign rx_o   = r_reg.rx;

endmodule
`default_nettype wire
